/* logic/pzg_consts.svh */
// Register indices, field positions, reset values and timing for the port zero block
`ifndef PZG_CONSTS_SVH
`define PZG_CONSTS_SVH

`define PZG_IDX_LATCH 16'hFE40
`define PZG_IDX_DIR 16'hFE41
`define PZG_IDX_FCTL 16'hFE42
`define PZG_IDX_LATCH_RAW 16'hFE43

`define PZG_BIT_HPWM_EN 7
`define PZG_BIT_LPWM_EN 6
`define PZG_BIT_IRQ_FLAG 5
`define PZG_BIT_IRQ_EN 4
`define PZG_BIT_CKO_EN 3

`define PZG_DIV_SUBCLK 3'h7
`define PZG_RST_LATCH 7'h00
`define PZG_RST_DIR 7'h00
`define PZG_RST_FCTL 8'h00
`define PZG_PIN_BIT_CLK 5
`define PZG_PIN_BIT_HPWM 6
`define PZG_PIN_BIT_VPWM_A 3
`define PZG_PIN_BIT_VPWM_B 4

`endif

/* logic/pzg_pkg.sv */
// Types shared by the port zero block
`default_nettype none
package pzg_pkg;
  typedef enum logic [1:0] {
    CKO_OFF,
    CKO_RUN,
    CKO_STOPPING
  } pzg_cko_state_type;
endpackage : pzg_pkg
`default_nettype wire

/* logic/pzg_port_zero.sv */
// Seven-bit general purpose port with PWM routing, clock output and low-level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "pzg_consts.svh"

module pzg_port_zero #(
  parameter logic [6:0] OPEN_DRAIN_MASK = 7'h00
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [17:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe_out,
  output logic [6:0] pullup_en_out,
  input wire logic high_pwm_in,
  input wire logic low_pwm_in,
  input wire logic voltage_pwm_a_en_in,
  input wire logic voltage_pwm_a_in,
  input wire logic voltage_pwm_b_en_in,
  input wire logic voltage_pwm_b_in,
  input wire logic sysclk_edge_in,
  input wire logic subclock_in,
  input wire logic light_standby_in,
  input wire logic deep_standby_in,
  output logic irq_out,
  output logic deep_standby_release_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction : hit

  // Last count of a half period: toggle after 2^div source edge pulses
  function automatic logic [5:0] half_last(input logic [2:0] div);
    half_last = 6'((7'h01 << div) - 7'h01);
  endfunction : half_last

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [6:0] latch_ff;
  logic [6:0] dir_ff;
  logic hpwm_en_ff;
  logic lpwm_en_ff;
  logic irq_flag_ff;
  logic irq_en_ff;
  logic [2:0] div_ff;
  pzg_pkg::pzg_cko_state_type cko_state_ff;
  pzg_pkg::pzg_cko_state_type nxt_cko_state;
  logic [6:0] pin_s1_ff;
  logic [6:0] pin_s2_ff;
  logic [6:0] pin_s3_ff;
  logic [6:0] pin_lvl_ff;
  logic sub_s1_ff;
  logic sub_s2_ff;
  logic sub_s3_ff;
  logic sub_lvl_ff;
  logic [5:0] div_cnt_ff;
  logic gen_clk_ff;
  logic src_prev_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [6:0] pin_ff;
  logic [6:0] pin_oe_ff;
  logic [6:0] pullup_ff;
  logic irq_ff;
  logic release_ff;
  logic access;
  logic wr;
  logic mapped;
  logic clk_src;
  logic clk_fall;
  logic cko_en;
  logic low_seen;
  logic standby;
  logic [6:0] nxt_pin;
  logic [6:0] nxt_oe;
  logic [31:0] nxt_rdata;
  localparam logic [7:0] RST_FCTL = `PZG_RST_FCTL;

  assign access = psel_in & penable_in & ~pready_ff;
  assign wr = access & pwrite_in;
  assign mapped = hit(paddr_in, `PZG_IDX_LATCH) | hit(paddr_in, `PZG_IDX_DIR)
                | hit(paddr_in, `PZG_IDX_FCTL) | hit(paddr_in, `PZG_IDX_LATCH_RAW);
  assign cko_en = (cko_state_ff != pzg_pkg::CKO_OFF);
  assign standby = light_standby_in | deep_standby_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin and subclock synchronisers

  always_ff @(posedge ref_clk_in) begin
    pin_s1_ff <= pin_in;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
    sub_s1_ff <= subclock_in;
    sub_s2_ff <= sub_s1_ff;
    sub_s3_ff <= sub_s2_ff;
  end

  // Level accepted only once two stages agree, per bit
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_lvl_ff <= 7'h00;
      sub_lvl_ff <= 1'b0;
    end else begin
      pin_lvl_ff <= (pin_s2_ff & pin_s3_ff) | (pin_lvl_ff & (pin_s2_ff ^ pin_s3_ff));
      if (sub_s2_ff == sub_s3_ff) begin
        sub_lvl_ff <= sub_s3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so every access ends in its second cycle

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access & ~mapped;
      prdata_ff <= access & ~pwrite_in ? nxt_rdata : 32'h0000_0000;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit(paddr_in, `PZG_IDX_LATCH)) begin
      nxt_rdata[6:0] = pin_lvl_ff;
    end else if (hit(paddr_in, `PZG_IDX_LATCH_RAW)) begin
      nxt_rdata[6:0] = latch_ff;
    end else if (hit(paddr_in, `PZG_IDX_DIR)) begin
      nxt_rdata[6:0] = dir_ff;
    end else if (hit(paddr_in, `PZG_IDX_FCTL)) begin
      nxt_rdata[7:0] = {hpwm_en_ff, lpwm_en_ff, irq_flag_ff, irq_en_ff, cko_en, div_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latch and direction; bit 7 is not stored, software keeps it 0

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      latch_ff <= `PZG_RST_LATCH;
    end else if (wr && (hit(paddr_in, `PZG_IDX_LATCH) || hit(paddr_in, `PZG_IDX_LATCH_RAW))) begin
      latch_ff <= pwdata_in[6:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      dir_ff <= `PZG_RST_DIR;
    end else if (wr && hit(paddr_in, `PZG_IDX_DIR)) begin
      dir_ff <= pwdata_in[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Function control fields

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      {hpwm_en_ff, lpwm_en_ff, irq_en_ff, div_ff} <= {RST_FCTL[7:6], RST_FCTL[4], RST_FCTL[2:0]};
    end else if (wr && hit(paddr_in, `PZG_IDX_FCTL)) begin
      hpwm_en_ff <= pwdata_in[`PZG_BIT_HPWM_EN];
      lpwm_en_ff <= pwdata_in[`PZG_BIT_LPWM_EN];
      irq_en_ff <= pwdata_in[`PZG_BIT_IRQ_EN];
      div_ff <= pwdata_in[2:0]; // Glitch-free only if software waits for enable 0
    end
  end

  // Any input-mode pin with latch 1 seen low
  assign low_seen = |(~dir_ff & latch_ff & ~pin_lvl_ff);

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_flag_ff <= RST_FCTL[`PZG_BIT_IRQ_FLAG];
    end else if (low_seen) begin
      irq_flag_ff <= 1'b1;
    end else if (wr && hit(paddr_in, `PZG_IDX_FCTL)) begin
      irq_flag_ff <= pwdata_in[`PZG_BIT_IRQ_FLAG];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_ff <= 1'b0;
      release_ff <= 1'b0;
    end else begin
      irq_ff <= irq_flag_ff & irq_en_ff;
      release_ff <= irq_flag_ff & irq_en_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock output generator, paced by source edge pulses

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_cnt_ff <= 6'h00;
      gen_clk_ff <= 1'b0;
    end else if (sysclk_edge_in) begin
      if (div_cnt_ff >= half_last(div_ff)) begin
        div_cnt_ff <= 6'h00;
        gen_clk_ff <= ~gen_clk_ff;
      end else begin
        div_cnt_ff <= div_cnt_ff + 6'h01;
      end
    end
  end

  assign clk_src = (div_ff == `PZG_DIV_SUBCLK) ? sub_lvl_ff : gen_clk_ff;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= clk_src;
    end
  end

  assign clk_fall = src_prev_ff & ~clk_src;

  // A cleared enable waits for the falling edge so no runt pulse reaches the pin
  always_comb begin
    nxt_cko_state = cko_state_ff;
    case (cko_state_ff)
      pzg_pkg::CKO_OFF: begin
        if (wr && hit(paddr_in, `PZG_IDX_FCTL) && pwdata_in[`PZG_BIT_CKO_EN]) begin
          nxt_cko_state = pzg_pkg::CKO_RUN;
        end
      end
      pzg_pkg::CKO_RUN: begin
        if (wr && hit(paddr_in, `PZG_IDX_FCTL) && !pwdata_in[`PZG_BIT_CKO_EN]) begin
          nxt_cko_state = pzg_pkg::CKO_STOPPING;
        end
      end
      pzg_pkg::CKO_STOPPING: begin
        if (wr && hit(paddr_in, `PZG_IDX_FCTL) && pwdata_in[`PZG_BIT_CKO_EN]) begin
          nxt_cko_state = pzg_pkg::CKO_RUN;
        end else if (clk_fall) begin
          nxt_cko_state = pzg_pkg::CKO_OFF;
        end
      end
      default: nxt_cko_state = pzg_pkg::CKO_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cko_state_ff <= pzg_pkg::CKO_OFF;
    end else begin
      cko_state_ff <= nxt_cko_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_comb begin
    nxt_pin = latch_ff;
    nxt_pin[`PZG_PIN_BIT_HPWM] = latch_ff[`PZG_PIN_BIT_HPWM] ^ (hpwm_en_ff & high_pwm_in);
    // Only reaches the pin through the direction gate below
    nxt_pin[`PZG_PIN_BIT_CLK] = latch_ff[`PZG_PIN_BIT_CLK]
                              ^ ((lpwm_en_ff & low_pwm_in) | (clk_src & cko_en));
    nxt_oe = dir_ff;
    if (!dir_ff[`PZG_PIN_BIT_VPWM_A] && voltage_pwm_a_en_in) begin
      nxt_pin[`PZG_PIN_BIT_VPWM_A] = voltage_pwm_a_in;
      nxt_oe[`PZG_PIN_BIT_VPWM_A] = 1'b1;
    end
    if (!dir_ff[`PZG_PIN_BIT_VPWM_B] && voltage_pwm_b_en_in) begin
      nxt_pin[`PZG_PIN_BIT_VPWM_B] = voltage_pwm_b_in;
      nxt_oe[`PZG_PIN_BIT_VPWM_B] = 1'b1;
    end
    nxt_oe = nxt_oe & ~(OPEN_DRAIN_MASK & nxt_pin);
  end

  // Frozen through standby so the board sees no change
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_ff <= 7'h00;
      pin_oe_ff <= 7'h00;
      pullup_ff <= 7'h00;
    end else if (!standby) begin
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_oe;
      pullup_ff <= ~dir_ff & latch_ff;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign pin_out = pin_ff;
  assign pin_oe_out = pin_oe_ff;
  assign pullup_en_out = pullup_ff;
  assign irq_out = irq_ff;
  assign deep_standby_release_out = release_ff;

endmodule : pzg_port_zero

`default_nettype wire

/* tb/pzg_port_zero_sva.sv */
// Port-level checker for the port zero block
`timescale 1ns/1ps
`default_nettype none
module pzg_port_zero_chk (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe_out,
  input wire logic [6:0] pullup_en_out,
  input wire logic light_standby_in,
  input wire logic deep_standby_in,
  input wire logic irq_out,
  input wire logic deep_standby_release_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_taken;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_frozen;
    (light_standby_in || deep_standby_in) ##1 (light_standby_in || deep_standby_in);
  endsequence
  a_access_answer: assert property (s_taken |=> pready_out ##1 !pready_out)
    else $error("access not answered in one cycle");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access");
  a_idle_data: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_upper_bits: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_release_irq: assert property (deep_standby_release_out == irq_out)
    else $error("standby release differs from irq");
  a_pullup_input: assert property ((pullup_en_out & pin_oe_out & 7'h67) == 7'h00)
    else $error("pull-up on a driven pin");
  a_standby_hold: assert property (s_frozen |-> $stable(pin_out) && $stable(pin_oe_out))
    else $error("pins moved in standby");
endmodule : pzg_port_zero_chk
bind pzg_port_zero pzg_port_zero_chk u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out),
  .light_standby_in(light_standby_in), .deep_standby_in(deep_standby_in),
  .irq_out(irq_out), .deep_standby_release_out(deep_standby_release_out));
`default_nettype wire

/* tb/pzg_board_model.sv */
// Board-side model of the seven port pins
`timescale 1ns/1ps
`default_nettype none
module pzg_board_model (
  input wire logic clk_in,
  input wire logic [6:0] out_in,
  input wire logic [6:0] oe_in,
  input wire logic [6:0] pullup_in,
  input wire logic [6:0] drv_en_in,
  input wire logic [6:0] drv_val_in,
  output logic [6:0] level_out
);
  logic [6:0] alt_ff = 7'h55;
  // Floating pins flip every cycle so a stale level never passes
  always_ff @(posedge clk_in) alt_ff <= ~alt_ff;
  always_comb level_out = (oe_in & out_in) | (~oe_in & drv_en_in & drv_val_in)
    | (~oe_in & ~drv_en_in & (pullup_in | alt_ff));
endmodule : pzg_board_model
`default_nettype wire

/* tb/port_zero_gpio_clkout_tb_top.sv */
// Self-checking bench for the port zero block
`timescale 1ns/1ps
`default_nettype none
`include "pzg_consts.svh"
module port_zero_gpio_clkout_tb_top;
  localparam logic [15:0] LA = `PZG_IDX_LATCH;
  localparam logic [15:0] DI = `PZG_IDX_DIR;
  localparam logic [15:0] FC = `PZG_IDX_FCTL;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
  logic hp = 0, lp = 0, ven = 0, vv = 0, lsb = 0, dsb = 0, sub = 0, sce = 1; // Steady source
  logic [17:0] pa = 0;
  logic [31:0] pwd = 0, r;
  logic [6:0] den = 0, dval = 0;
  wire logic [31:0] prd;
  wire logic rdy, err, irq, rel;
  wire logic [6:0] po, poe, pu, lvl;
  int n_fail = 0, n_compared = 0;
  initial forever #10 clk = ~clk;
  // Subclock source: one level change every 8 cycles
  initial forever begin
    repeat (8) @(posedge clk);
    sub <= ~sub;
  end
  pzg_port_zero dut (.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .pin_in(lvl), .pin_out(po), .pin_oe_out(poe), .pullup_en_out(pu),
    .high_pwm_in(hp), .low_pwm_in(lp), .voltage_pwm_a_en_in(ven), .voltage_pwm_a_in(vv),
    .voltage_pwm_b_en_in(ven), .voltage_pwm_b_in(vv), .sysclk_edge_in(sce),
    .subclock_in(sub), .light_standby_in(lsb), .deep_standby_in(dsb), .irq_out(irq),
    .deep_standby_release_out(rel));
  pzg_board_model board (.clk_in(clk), .out_in(po), .oe_in(poe), .pullup_in(pu),
    .drv_en_in(den), .drv_val_in(dval), .level_out(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Starts one edge late so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= {idx, 2'b00};
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(nm, r, exp);
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Settles past the first uneven half period, then counts pin five changes over 128 edges
  task automatic count_edges(output int n);
    logic p;
    wt(40);
    n = 0;
    p = po[5];
    repeat (128) begin
      @(posedge clk);
      n += int'(po[5] !== p);
      p = po[5];
    end
  endtask : count_edges
  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc("dir rst", DI, 32'h0);
    rdc("fctl rst", FC, 32'h0);
    rdc("raw rst", `PZG_IDX_LATCH_RAW, 32'h0);
    rdc("unmapped", 16'hFE44, 32'h0);
    check("slverr", {31'h0, e}, 32'h1);
  endtask : t_regs
  task automatic t_pins();
    wr(DI, 8'h7F);
    wr(LA, 8'h55);
    wt(6);
    check("oe", {25'h0, poe}, 32'h7F);
    check("out", {25'h0, po}, 32'h55);
    rdc("pins out", LA, 32'h55);
    den <= 7'h70;
    dval <= 7'h50;
    wr(DI, 8'h0F);
    wr(LA, 8'hF2);
    wt(6);
    check("pullup", {25'h0, pu}, 32'h70);
    rdc("pins mixed", LA, 32'h52);
    rdc("raw", `PZG_IDX_LATCH_RAW, 32'h72);
    den <= 7'h00;
  endtask : t_pins
  task automatic t_flag();
    wr(DI, 8'h00);
    wr(LA, 8'h01);
    wt(6);
    wr(FC, 8'h00);
    den <= 7'h01;
    dval <= 7'h00;
    wt(8);
    rdc("flag set", FC, 32'h20);
    wr(FC, 8'h10);
    wt(3);
    check("irq on", {30'h0, irq, rel}, 32'h3);
    den <= 7'h00;
    wt(8);
    rdc("flag kept", FC, 32'h30);
    wr(FC, 8'h10);
    wt(3);
    check("irq off", {31'h0, irq}, 32'h0);
  endtask : t_flag
  task automatic t_pwm();
    wr(DI, 8'h60);
    wr(LA, 8'h00);
    wr(FC, 8'hC0);
    hp <= 1'b1;
    lp <= 1'b1;
    wt(3);
    check("pwm on", {25'h0, po & 7'h60}, 32'h60);
    wr(LA, 8'h60);
    hp <= 1'b0;
    wt(3);
    check("pwm xor", {25'h0, po & 7'h60}, 32'h40);
    ven <= 1'b1;
    vv <= 1'b1;
    wt(3);
    check("vpwm", {18'h0, poe & 7'h18, po & 7'h18}, 32'hC18);
    ven <= 1'b0;
    lp <= 1'b0;
    wr(FC, 8'h00);
  endtask : t_pwm
  task automatic t_stby();
    wr(DI, 8'h7F);
    wr(LA, 8'h00);
    lsb <= 1'b1;
    wr(LA, 8'h7F);
    wt(3);
    check("frozen", {25'h0, po}, 32'h0);
    lsb <= 1'b0;
    wt(3);
    check("thawed", {25'h0, po}, 32'h7F);
    dsb <= 1'b1;
    wr(LA, 8'h00);
    wt(3);
    check("deep frozen", {25'h0, po}, 32'h7F);
    dsb <= 1'b0;
    wt(3);
    check("deep thawed", {25'h0, po}, 32'h0);
  endtask : t_stby
  task automatic t_clk();
    int c;
    logic p;
    wr(LA, 8'h00);
    wr(DI, 8'h20);
    for (int d = 0; d < 5; d++) begin
      wr(FC, 8'h08 | 8'(d));
      count_edges(c);
      check("cko rate", 32'(c), 32'(128 >> d));
      p = 1'b1;
      for (c = 0; c < 80 && !(po[5] === 1'b1 && p === 1'b0); c++) begin
        p = po[5];
        @(posedge clk);
      end
      wr(FC, 8'(d));
      apb(1'b0, FC, 8'h00);
      if (d == 4) check("cko hold", r, 32'h0C);
      for (c = 0; c < 40 && r[3] !== 1'b0; c++) apb(1'b0, FC, 8'h00);
      check("cko off", {po[5], r[30:0]}, 32'(d));
    end
    wr(FC, 8'h0F);
    count_edges(c);
    check("cko sub", 32'(c), 32'h10);
    wr(FC, 8'h07);
    apb(1'b0, FC, 8'h00);
    for (c = 0; c < 40 && r[3] !== 1'b0; c++) apb(1'b0, FC, 8'h00);
    check("cko sub off", {po[5], r[30:0]}, 32'h07);
    wr(DI, 8'h00);
    wr(FC, 8'h08);
    wt(20);
    check("cko input", {31'h0, poe[5]}, 32'h0);
  endtask : t_clk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pins();
    t_flag();
    t_pwm();
    t_stby();
    t_clk();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    check("watchdog", 32'h0, 32'h1);
    tally_and_finish();
  end
endmodule : port_zero_gpio_clkout_tb_top
`default_nettype wire
